// File: xfer_pkg.sv
// constants, operation codes and operand kinds for the data-transfer execution unit
// Operation
// RULE1 - index-register external read: 8-bit address from index register, byte into accumulator
// RULE2 - pointer external read: full 16-bit data pointer address, byte into accumulator
// RULE3 - index-register external write: accumulator stored at 8-bit address from index register
// RULE4 - pointer external write: accumulator stored at 16-bit data pointer address
// RULE5 - pointer load writes the 16-bit immediate into the data pointer at once
// RULE6 - pointer code read: fetch code byte at accumulator plus data pointer into accumulator
// RULE7 - program-counter code read: code byte at accumulator plus counter into accumulator
// RULE8 - push copies a direct byte onto the internal RAM stack, moving stack pointer
// RULE9 - pop takes the stack top into a direct location, moving stack pointer
// RULE10 - nibble exchange swaps only low nibbles of accumulator and indirect byte
// RULE11 - indirect exchange swaps whole accumulator with the index-addressed RAM byte
// RULE12 - direct exchange swaps accumulator with a direct RAM or special register byte
// RULE13 - register exchange swaps accumulator and working register together
// RULE14 - direct-to-direct move copies one direct location to another in one operation
// RULE15 - indirect-to-direct move copies the index-addressed byte to a direct location
// RULE16 - direct-to-indirect move copies a direct byte to the index-addressed RAM byte
// RULE17 - working register loads from a direct byte or an immediate constant
// RULE18 - accumulator loads from register, direct, indirect or immediate source
// RULE19 - register operands pick one of eight working registers in active bank
// RULE20 - only working registers zero and one may serve as index registers
// RULE21 - direct operands reach the lower 128 RAM bytes or any special register
// RULE22 - push increments stack pointer before writing; pop reads before decrementing
package xfer_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int IRAM_DEPTH = 256;
  localparam logic [7:0] SP_RESET = 8'h07; // stack pointer after reset
  localparam logic [7:0] SFR_BASE = 8'h80; // direct addresses at or above go to special registers
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // operand kinds
  localparam logic [3:0] K_NONE = 4'h0;
  localparam logic [3:0] K_ACC = 4'h1;
  localparam logic [3:0] K_REG = 4'h2;
  localparam logic [3:0] K_DIR = 4'h3;
  localparam logic [3:0] K_IND = 4'h4;
  localparam logic [3:0] K_IMM = 4'h5;
  localparam logic [3:0] K_CODE = 4'h6;
  localparam logic [3:0] K_XIND = 4'h7;
  localparam logic [3:0] K_XPTR = 4'h8;
  localparam logic [3:0] K_STACK = 4'h9;
  localparam logic [3:0] K_PTR = 4'ha;

  // operation codes handed over by the decoder
  typedef enum logic [4:0] {
    OP_ACC_REG = 5'h00, OP_ACC_DIR = 5'h01, OP_ACC_IND = 5'h02, OP_ACC_IMM = 5'h03,
    OP_REG_ACC = 5'h04, OP_REG_DIR = 5'h05, OP_REG_IMM = 5'h06, OP_DIR_ACC = 5'h07,
    OP_DIR_REG = 5'h08, OP_DIR_DIR = 5'h09, OP_DIR_IND = 5'h0a, OP_DIR_IMM = 5'h0b,
    OP_IND_ACC = 5'h0c, OP_IND_DIR = 5'h0d, OP_IND_IMM = 5'h0e, OP_PTR_LOAD = 5'h0f,
    OP_CODE_PTR = 5'h10, OP_CODE_PROG = 5'h11, OP_XRD_IND = 5'h12, OP_XRD_PTR = 5'h13,
    OP_XWR_IND = 5'h14, OP_XWR_PTR = 5'h15, OP_PUSH = 5'h16, OP_POP = 5'h17,
    OP_SWAP_REG = 5'h18, OP_SWAP_DIR = 5'h19, OP_SWAP_IND = 5'h1a, OP_SWAP_NIB = 5'h1b
  } xfer_op_e;

  // sequencer states
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_FETCH = 6'b000010, S_SFR = 6'b000100,
    S_MEM = 6'b001000, S_STORE = 6'b010000, S_WACK = 6'b100000
  } xfer_state_e;
endpackage

// File: xfer_unit.sv
// data-transfer execution unit: moves, exchanges, stack, code and external RAM transfers
`timescale 1ns/100ps
module xfer_unit import xfer_pkg::*; (
  input wire logic MCLK_I, // 125 MHz clock
  input wire logic RST_I, // synchronous reset, active high
  input wire logic START_I, // one-cycle pulse: execute OP_I
  input wire logic [4:0] OP_I, // operation code
  input wire logic [2:0] REG_I, // working register number
  input wire logic [1:0] BANK_I, // active register bank
  input wire logic [7:0] DIR_SRC_I, // source direct address
  input wire logic [7:0] DIR_DST_I, // destination direct address
  input wire logic [7:0] IMM_I, // 8-bit immediate
  input wire logic [15:0] IMM16_I, // wide immediate
  input wire logic [15:0] PROG_CNT_I, // program counter of next instruction
  output logic BUSY_O, // operation in progress
  output logic DONE_O, // one-cycle pulse at completion
  output logic [7:0] ACC_O, // accumulator
  output logic [15:0] DATA_PTR_O, // data pointer
  output logic [7:0] SP_O, // stack pointer
  output logic [7:0] SFR_ADDR_O, // special register address
  output logic SFR_RD_O, // special register read pulse
  output logic SFR_WR_O, // special register write pulse
  output logic [7:0] SFR_WDATA_O, // special register write data
  input wire logic [7:0] SFR_RDATA_I, // read data, valid the cycle after SFR_RD_O
  output logic [15:0] CODE_ADDR_O, // code memory address
  output logic CODE_RD_O, // code read request, held until CODE_VALID_I
  input wire logic [7:0] CODE_DATA_I, // code byte
  input wire logic CODE_VALID_I, // code byte valid
  output logic [15:0] XADDR_O, // external RAM address
  output logic XRD_O, // external read request, held until XACK_I
  output logic XWR_O, // external write request, held until XACK_I
  output logic [7:0] XWDATA_O, // external write data
  input wire logic [7:0] XRDATA_I, // external read data
  input wire logic XACK_I // external access done
);
  // source operand kind for each operation
  function automatic logic [3:0] src_kind(input xfer_op_e op);
    unique case (op)
      OP_ACC_REG, OP_SWAP_REG, OP_DIR_REG: src_kind = K_REG;
      OP_ACC_DIR, OP_REG_DIR, OP_DIR_DIR, OP_IND_DIR, OP_PUSH, OP_SWAP_DIR: src_kind = K_DIR;
      OP_ACC_IND, OP_DIR_IND, OP_SWAP_IND, OP_SWAP_NIB: src_kind = K_IND;
      OP_ACC_IMM, OP_REG_IMM, OP_DIR_IMM, OP_IND_IMM: src_kind = K_IMM;
      OP_CODE_PTR, OP_CODE_PROG: src_kind = K_CODE;
      OP_XRD_IND: src_kind = K_XIND;
      OP_XRD_PTR: src_kind = K_XPTR;
      OP_POP: src_kind = K_STACK;
      default: src_kind = K_ACC;
    endcase
  endfunction

  // destination operand kind for each operation
  function automatic logic [3:0] dst_kind(input xfer_op_e op);
    unique case (op)
      OP_REG_ACC, OP_REG_DIR, OP_REG_IMM, OP_SWAP_REG: dst_kind = K_REG;
      OP_DIR_ACC, OP_DIR_REG, OP_DIR_DIR, OP_DIR_IND, OP_DIR_IMM, OP_POP,
      OP_SWAP_DIR: dst_kind = K_DIR;
      OP_IND_ACC, OP_IND_DIR, OP_IND_IMM, OP_SWAP_IND, OP_SWAP_NIB: dst_kind = K_IND;
      OP_XWR_IND: dst_kind = K_XIND;
      OP_XWR_PTR: dst_kind = K_XPTR;
      OP_PUSH: dst_kind = K_STACK;
      OP_PTR_LOAD: dst_kind = K_PTR;
      OP_XRD_IND, OP_XRD_PTR, OP_CODE_PTR, OP_CODE_PROG: dst_kind = K_ACC;
      default: dst_kind = K_ACC;
    endcase
  endfunction

  // exchange operations also load the accumulator
  function automatic logic is_swap(input xfer_op_e op);
    is_swap = (op == OP_SWAP_REG) || (op == OP_SWAP_DIR) || (op == OP_SWAP_IND) ||
              (op == OP_SWAP_NIB);
  endfunction

  logic [7:0] iram [IRAM_DEPTH];
  xfer_state_e state_q;
  xfer_op_e op_q;
  logic [2:0] reg_q;
  logic [1:0] bank_q;
  logic [7:0] dsrc_q, ddst_q, imm_q, acc_q, sp_q, data_q;
  logic [15:0] imm16_q, pc_q, data_pointer_q;
  logic [3:0] sk, dk;
  logic [7:0] reg_addr, ind_addr, src_dir_val, loc_wval;
  logic src_sfr, dst_sfr;

  // operand addressing
  always_comb begin
    sk = src_kind(op_q);
    dk = dst_kind(op_q);
    reg_addr = {3'b000, bank_q, reg_q}; // [RULE19]
    ind_addr = iram[{3'b000, bank_q, 2'b00, reg_q[0]}]; // only register 0 or 1 [RULE20]
    src_sfr = (sk == K_DIR) && (dsrc_q >= SFR_BASE); // [RULE21]
    dst_sfr = (dk == K_DIR) && (ddst_q >= SFR_BASE); // [RULE21]
    src_dir_val = iram[dsrc_q];
    // swaps write the old accumulator back, nibble swap keeps the high nibble
    if (op_q == OP_SWAP_NIB) begin
      loc_wval = {data_q[7:4], acc_q[3:0]}; // [RULE10]
    end else if (is_swap(op_q)) begin
      loc_wval = acc_q; // [RULE11] [RULE12] [RULE13]
    end else begin
      loc_wval = data_q; // [RULE14] [RULE15] [RULE16] [RULE17]
    end
  end

  // sequencer: fetch source, wait on slow memories, then store
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: if (START_I) state_q <= S_FETCH;
        S_FETCH: begin
          if (src_sfr) begin
            state_q <= S_SFR;
          end else if (sk == K_CODE || sk == K_XIND || sk == K_XPTR) begin
            state_q <= S_MEM;
          end else begin
            state_q <= S_STORE;
          end
        end
        S_SFR: if (!SFR_RD_O) state_q <= S_STORE; // sit out the one-cycle read latency
        S_MEM: if ((CODE_RD_O && CODE_VALID_I) || (XRD_O && XACK_I)) state_q <= S_STORE;
        S_STORE: state_q <= (dk == K_XIND || dk == K_XPTR) ? S_WACK : S_IDLE;
        S_WACK: if (XACK_I) state_q <= S_IDLE;
      endcase
    end
  end

  // operand capture at start
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      op_q <= OP_ACC_REG;
      reg_q <= 3'h0;
      bank_q <= 2'h0;
      dsrc_q <= BYTE_ZERO;
      ddst_q <= BYTE_ZERO;
      imm_q <= BYTE_ZERO;
      imm16_q <= WORD_ZERO;
      pc_q <= WORD_ZERO;
    end else if (state_q == S_IDLE && START_I) begin
      op_q <= xfer_op_e'(OP_I);
      reg_q <= REG_I;
      bank_q <= BANK_I;
      dsrc_q <= DIR_SRC_I;
      ddst_q <= DIR_DST_I;
      imm_q <= IMM_I;
      imm16_q <= IMM16_I;
      pc_q <= PROG_CNT_I;
    end
  end

  // source value
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      data_q <= BYTE_ZERO;
    end else if (state_q == S_FETCH) begin
      unique case (sk)
        K_REG: data_q <= iram[reg_addr];
        K_DIR: data_q <= src_dir_val;
        K_IND: data_q <= iram[ind_addr];
        K_IMM: data_q <= imm_q;
        K_STACK: data_q <= iram[sp_q]; // read before decrement [RULE9] [RULE22]
        default: data_q <= acc_q;
      endcase
    end else if (state_q == S_SFR && !SFR_RD_O) begin
      // read data stands only in the cycle after the read pulse
      data_q <= SFR_RDATA_I; // [RULE21]
    end else if (state_q == S_MEM && CODE_RD_O && CODE_VALID_I) begin
      data_q <= CODE_DATA_I;
    end else if (state_q == S_MEM && XRD_O && XACK_I) begin
      data_q <= XRDATA_I;
    end
  end

  // special register port
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      SFR_ADDR_O <= BYTE_ZERO;
      SFR_RD_O <= 1'b0;
      SFR_WR_O <= 1'b0;
      SFR_WDATA_O <= BYTE_ZERO;
    end else begin
      SFR_RD_O <= (state_q == S_FETCH) && src_sfr;
      SFR_WR_O <= (state_q == S_STORE) && dst_sfr; // [RULE12]
      if (state_q == S_FETCH && src_sfr) begin
        SFR_ADDR_O <= dsrc_q;
      end else if (state_q == S_STORE && dst_sfr) begin
        SFR_ADDR_O <= ddst_q;
        SFR_WDATA_O <= loc_wval;
      end
    end
  end

  // code memory and external RAM requests
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      CODE_ADDR_O <= WORD_ZERO;
      CODE_RD_O <= 1'b0;
      XADDR_O <= WORD_ZERO;
      XRD_O <= 1'b0;
      XWR_O <= 1'b0;
      XWDATA_O <= BYTE_ZERO;
    end else begin
      if (state_q == S_FETCH && sk == K_CODE) begin
        CODE_RD_O <= 1'b1;
        if (op_q == OP_CODE_PTR) begin
          CODE_ADDR_O <= data_pointer_q + {8'h00, acc_q}; // [RULE6]
        end else begin
          CODE_ADDR_O <= pc_q + {8'h00, acc_q}; // [RULE7]
        end
      end else if (CODE_VALID_I) begin
        CODE_RD_O <= 1'b0;
      end
      if (state_q == S_FETCH && (sk == K_XIND || sk == K_XPTR)) begin
        XRD_O <= 1'b1;
        XADDR_O <= (sk == K_XIND) ? {8'h00, ind_addr} : data_pointer_q; // [RULE1] [RULE2]
      end else if (state_q == S_STORE && (dk == K_XIND || dk == K_XPTR)) begin
        XWR_O <= 1'b1;
        XWDATA_O <= acc_q; // [RULE3] [RULE4]
        XADDR_O <= (dk == K_XIND) ? {8'h00, ind_addr} : data_pointer_q; // [RULE3] [RULE4]
      end else if (XACK_I) begin
        XRD_O <= 1'b0;
        XWR_O <= 1'b0;
      end
    end
  end

  // accumulator, data pointer and stack pointer
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      acc_q <= BYTE_ZERO;
      data_pointer_q <= WORD_ZERO;
      sp_q <= SP_RESET;
    end else if (state_q == S_STORE) begin
      if (op_q == OP_SWAP_NIB) begin
        acc_q <= {acc_q[7:4], data_q[3:0]}; // [RULE10]
      end else if (dk == K_ACC || is_swap(op_q)) begin
        acc_q <= data_q; // [RULE1] [RULE2] [RULE6] [RULE7] [RULE13] [RULE18]
      end
      if (dk == K_PTR) data_pointer_q <= imm16_q; // [RULE5]
      if (op_q == OP_PUSH) sp_q <= sp_q + 8'h01; // [RULE8] [RULE22]
      if (op_q == OP_POP) sp_q <= sp_q - 8'h01; // [RULE9] [RULE22]
    end
  end

  // internal RAM writes: registers, indirect bytes, lower direct bytes, stack
  always_ff @(posedge MCLK_I) begin
    if (state_q == S_STORE && !RST_I) begin
      if (dk == K_REG) iram[reg_addr] <= loc_wval; // [RULE13] [RULE17]
      if (dk == K_IND) iram[ind_addr] <= loc_wval; // [RULE10] [RULE11] [RULE16]
      if (dk == K_DIR && !dst_sfr) iram[ddst_q] <= loc_wval; // [RULE12] [RULE14] [RULE15]
      if (dk == K_STACK) iram[sp_q + 8'h01] <= data_q; // write above old top [RULE8] [RULE22]
    end
  end

  // status outputs
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      BUSY_O <= 1'b0;
      DONE_O <= 1'b0;
    end else begin
      BUSY_O <= (state_q == S_IDLE) ? START_I :
                !((state_q == S_STORE && dk != K_XIND && dk != K_XPTR) ||
                  (state_q == S_WACK && XACK_I));
      DONE_O <= (state_q == S_STORE && dk != K_XIND && dk != K_XPTR) ||
                (state_q == S_WACK && XACK_I);
    end
  end

  assign ACC_O = acc_q;
  assign DATA_PTR_O = data_pointer_q;
  assign SP_O = sp_q;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  sequence start_of(xfer_op_e op);
    state_q == S_IDLE && START_I && OP_I == op;
  endsequence

  acc_imm_load_a: assert property ( // [RULE18]
    start_of(OP_ACC_IMM) |-> ##3 ACC_O == $past(IMM_I, 3))
    else $error("accumulator immediate load wrong");
  ptr_wide_load_a: assert property ( // [RULE5]
    start_of(OP_PTR_LOAD) |-> ##3 DATA_PTR_O == $past(IMM16_I, 3))
    else $error("pointer load wrong");
  push_sp_up_a: assert property ( // [RULE22]
    state_q == S_STORE && op_q == OP_PUSH |=> SP_O == $past(SP_O) + 8'h01)
    else $error("push did not raise stack pointer");
  pop_sp_down_a: assert property ( // [RULE9]
    state_q == S_STORE && op_q == OP_POP |=> SP_O == $past(SP_O) - 8'h01)
    else $error("pop did not lower stack pointer");
  xram_short_addr_a: assert property ( // [RULE1]
    $rose(XRD_O) && op_q == OP_XRD_IND |-> XADDR_O[15:8] == 8'h00)
    else $error("index external address not 8-bit");
  code_ptr_addr_a: assert property ( // [RULE6]
    $rose(CODE_RD_O) && op_q == OP_CODE_PTR |-> CODE_ADDR_O == data_pointer_q + {8'h00, acc_q})
    else $error("code read address wrong");
  nibble_swap_a: assert property ( // [RULE10]
    state_q == S_STORE && op_q == OP_SWAP_NIB |=>
      ACC_O == {$past(acc_q[7:4]), $past(data_q[3:0])})
    else $error("nibble exchange wrong");
  xwrite_data_a: assert property ( // [RULE3]
    $rose(XWR_O) |-> (XWDATA_O == ACC_O) ##1 (XWR_O || DONE_O))
    else $error("external write data wrong");
  sfr_read_wait_a: assert property ( // [RULE21]
    SFR_RD_O |=> !SFR_RD_O && state_q == S_SFR)
    else $error("special register read not held for its latency");
endmodule

// File: xfer_mem_model.sv
// far-side model: special registers, code memory and external RAM
`timescale 1ns/100ps
module xfer_mem_model (
  input wire logic clk_i, // clock
  input wire logic slow_i, // add wait states
  input wire logic [7:0] sfr_addr_i, // sfr address
  input wire logic sfr_rd_i, // sfr read pulse
  input wire logic sfr_wr_i, // sfr write pulse
  input wire logic [7:0] sfr_wdata_i, // sfr write data
  output logic [7:0] sfr_rdata_o, // sfr read data
  input wire logic [15:0] code_addr_i, // code address
  input wire logic code_rd_i, // code request
  output logic [7:0] code_data_o, // code byte
  output logic code_valid_o, // code byte valid
  input wire logic [15:0] xaddr_i, // xram address
  input wire logic xrd_i, // xram read
  input wire logic xwr_i, // xram write
  input wire logic [7:0] xwdata_i, // xram write data
  output logic [7:0] xrdata_o, // xram read data
  output logic xack_o // xram done pulse
);
  logic [7:0] sfr [256];
  logic [7:0] xram [bit [15:0]];
  logic [7:0] junk = 8'h3c;
  logic [7:0] sfr_q = 8'h00;
  logic [7:0] code_q = 8'h00;
  logic [7:0] xr_q = 8'h00;
  logic sv = 1'b0;
  logic cv = 1'b0;
  logic xv = 1'b0;
  logic [2:0] ccnt = 3'h0;
  logic [2:0] xcnt = 3'h0;
  logic [2:0] lat;
  function automatic logic [7:0] code_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  // data lines show a changing pattern outside their valid cycle
  assign lat = slow_i ? 3'h4 : 3'h0;
  assign sfr_rdata_o = sv ? sfr_q : junk;
  assign code_data_o = cv ? code_q : ~junk;
  assign xrdata_o = xv ? xr_q : junk ^ 8'h55;
  assign code_valid_o = cv;
  assign xack_o = xv;
  // sfr port: one-cycle read latency
  always @(posedge clk_i) begin
    junk <= junk + 8'h01;
    sv <= sfr_rd_i;
    if (sfr_rd_i) sfr_q <= sfr[sfr_addr_i];
    if (sfr_wr_i) sfr[sfr_addr_i] <= sfr_wdata_i;
  end
  // code port: answers after 1 or 5 cycles
  always @(posedge clk_i) begin
    cv <= 1'b0;
    ccnt <= 3'h0;
    if (code_rd_i && !cv) begin
      if (ccnt == lat) begin
        cv <= 1'b1;
        code_q <= code_byte(code_addr_i);
      end else ccnt <= ccnt + 3'h1;
    end
  end
  // external RAM: write or read completes with the ack pulse
  always @(posedge clk_i) begin
    xv <= 1'b0;
    xcnt <= 3'h0;
    if ((xrd_i || xwr_i) && !xv) begin
      if (xcnt == lat) begin
        xv <= 1'b1;
        if (xwr_i) xram[xaddr_i] = xwdata_i;
        xr_q <= xram.exists(xaddr_i) ? xram[xaddr_i] : 8'hee;
      end else xcnt <= xcnt + 3'h1;
    end
  end
endmodule

// File: cpu_data_transfer_instructions_tb.sv
// testbench for the data-transfer execution unit
`timescale 1ns/100ps
module cpu_data_transfer_instructions_tb import xfer_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic slow = 1'b0;
  xfer_op_e op = OP_ACC_IMM;
  logic [2:0] rg = 3'h0;
  logic [1:0] bank = 2'h0;
  logic [7:0] dsrc = 8'h00, ddst = 8'h00, imm = 8'h00;
  logic [15:0] imm16 = 16'h0000, pc = 16'h0000;
  logic busy, done, sfr_rd, sfr_wr, code_rd, code_v, xrd, xwr, xack;
  logic [7:0] acc, sp, sfr_addr, sfr_wd, sfr_rd_d, code_d, xwd, xrd_d;
  logic [15:0] data_pointer, code_a, xaddr;
  int n_errors = 0;
  int checked = 0;
  xfer_unit u_xfer_unit (.MCLK_I(clk), .RST_I(rst), .START_I(start), .OP_I(op),
    .REG_I(rg), .BANK_I(bank), .DIR_SRC_I(dsrc), .DIR_DST_I(ddst), .IMM_I(imm),
    .IMM16_I(imm16), .PROG_CNT_I(pc), .BUSY_O(busy), .DONE_O(done), .ACC_O(acc),
    .DATA_PTR_O(data_pointer), .SP_O(sp), .SFR_ADDR_O(sfr_addr), .SFR_RD_O(sfr_rd),
    .SFR_WR_O(sfr_wr), .SFR_WDATA_O(sfr_wd), .SFR_RDATA_I(sfr_rd_d), .CODE_ADDR_O(code_a),
    .CODE_RD_O(code_rd), .CODE_DATA_I(code_d), .CODE_VALID_I(code_v), .XADDR_O(xaddr),
    .XRD_O(xrd), .XWR_O(xwr), .XWDATA_O(xwd), .XRDATA_I(xrd_d), .XACK_I(xack));
  xfer_mem_model u_xfer_mem_model (.clk_i(clk), .slow_i(slow), .sfr_addr_i(sfr_addr),
    .sfr_rd_i(sfr_rd), .sfr_wr_i(sfr_wr), .sfr_wdata_i(sfr_wd), .sfr_rdata_o(sfr_rd_d),
    .code_addr_i(code_a), .code_rd_i(code_rd), .code_data_o(code_d), .code_valid_o(code_v),
    .xaddr_i(xaddr), .xrd_i(xrd), .xwr_i(xwr), .xwdata_i(xwd), .xrdata_o(xrd_d),
    .xack_o(xack));
  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one operation: pulse start, wait for done under a bound
  task automatic ex(input xfer_op_e o, input logic [2:0] r, input logic [7:0] a, b, v);
    int n;
    @(negedge clk);
    op = o;
    rg = r;
    dsrc = a;
    ddst = b;
    imm = v;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk("busy", {15'h0, busy}, 16'h0001);
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("done", {15'h0, done}, 16'h0001);
  endtask
  task automatic ldacc(input logic [7:0] v);
    ex(OP_ACC_IMM, 3'h0, 8'h00, 8'h00, v);
  endtask
  task automatic t_reset;
    chk("acc", acc, 16'h0000);
    chk("data_pointer", data_pointer, 16'h0000);
    chk("sp", sp, 16'h0007);
    chk("busy", busy, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_regs;
    bank = 2'h1;
    for (int i = 0; i < 8; i++) ex(OP_REG_IMM, 3'(i), 8'h00, 8'h00, 8'h30 + 8'(i));
    bank = 2'h0;
    ex(OP_REG_IMM, 3'h3, 8'h00, 8'h00, 8'h11);
    bank = 2'h1;
    for (int i = 0; i < 8; i++) begin
      ex(OP_ACC_REG, 3'(i), 8'h00, 8'h00, 8'h00);
      chk("acc reg", acc, 16'h0030 + 16'(i));
    end
    bank = 2'h0;
    $display("test registers done");
  endtask
  task automatic t_direct;
    ex(OP_DIR_IMM, 3'h0, 8'h00, 8'h20, 8'ha5);
    ex(OP_DIR_DIR, 3'h0, 8'h20, 8'h21, 8'h00);
    ex(OP_REG_DIR, 3'h2, 8'h21, 8'h00, 8'h00);
    ex(OP_ACC_REG, 3'h2, 8'h00, 8'h00, 8'h00);
    chk("dir move", acc, 16'h00a5);
    ex(OP_DIR_IMM, 3'h0, 8'h00, 8'h90, 8'h6e);
    @(negedge clk); // the far side takes the write pulse at the next edge
    chk("sfr wr", u_xfer_mem_model.sfr[8'h90], 16'h006e);
    ex(OP_ACC_DIR, 3'h0, 8'h90, 8'h00, 8'h00);
    chk("sfr rd", acc, 16'h006e);
    $display("test direct done");
  endtask
  task automatic t_indirect;
    ex(OP_REG_IMM, 3'h0, 8'h00, 8'h00, 8'h40);
    ex(OP_REG_IMM, 3'h1, 8'h00, 8'h00, 8'h41);
    ex(OP_DIR_IMM, 3'h0, 8'h00, 8'h22, 8'h3c);
    ex(OP_IND_DIR, 3'h0, 8'h22, 8'h00, 8'h00);
    ex(OP_IND_IMM, 3'h3, 8'h00, 8'h00, 8'hc7);
    ex(OP_DIR_IND, 3'h1, 8'h00, 8'h23, 8'h00);
    ex(OP_ACC_DIR, 3'h0, 8'h23, 8'h00, 8'h00);
    chk("ind to dir", acc, 16'h00c7);
    ex(OP_ACC_DIR, 3'h0, 8'h40, 8'h00, 8'h00);
    chk("dir to ind", acc, 16'h003c);
    ex(OP_ACC_IND, 3'h0, 8'h00, 8'h00, 8'h00);
    chk("acc ind", acc, 16'h003c);
    $display("test indirect done");
  endtask
  task automatic t_swap;
    ldacc(8'h12);
    ex(OP_SWAP_NIB, 3'h0, 8'h00, 8'h00, 8'h00);
    chk("nib acc", acc, 16'h001c);
    ex(OP_ACC_DIR, 3'h0, 8'h40, 8'h00, 8'h00);
    chk("nib ram", acc, 16'h0032);
    ldacc(8'h55);
    ex(OP_SWAP_IND, 3'h0, 8'h00, 8'h00, 8'h00);
    chk("xind acc", acc, 16'h0032);
    ex(OP_ACC_IND, 3'h0, 8'h00, 8'h00, 8'h00);
    chk("xind ram", acc, 16'h0055);
    ex(OP_SWAP_DIR, 3'h0, 8'h20, 8'h20, 8'h00);
    chk("xdir acc", acc, 16'h00a5);
    ex(OP_ACC_DIR, 3'h0, 8'h20, 8'h00, 8'h00);
    chk("xdir ram", acc, 16'h0055);
    ex(OP_SWAP_REG, 3'h0, 8'h00, 8'h00, 8'h00);
    chk("xreg acc", acc, 16'h0040);
    ex(OP_ACC_REG, 3'h0, 8'h00, 8'h00, 8'h00);
    chk("xreg reg", acc, 16'h0055);
    $display("test exchange done");
  endtask
  task automatic t_code;
    imm16 = 16'h1234;
    ex(OP_PTR_LOAD, 3'h0, 8'h00, 8'h00, 8'h00);
    chk("data_pointer", data_pointer, 16'h1234);
    ldacc(8'hf0);
    slow = 1'b1;
    ex(OP_CODE_PTR, 3'h0, 8'h00, 8'h00, 8'h00);
    chk("code data_pointer", acc, u_xfer_mem_model.code_byte(16'h1324));
    pc = 16'hfff0;
    ldacc(8'h20);
    ex(OP_CODE_PROG, 3'h0, 8'h00, 8'h00, 8'h00);
    chk("code pc", acc, u_xfer_mem_model.code_byte(16'h0010));
    slow = 1'b0;
    $display("test code done");
  endtask
  task automatic t_xram;
    ldacc(8'h77);
    ex(OP_XWR_PTR, 3'h0, 8'h00, 8'h00, 8'h00);
    chk("xwr ptr", u_xfer_mem_model.xram[16'h1234], 16'h0077);
    ldacc(8'h00);
    ex(OP_XRD_PTR, 3'h0, 8'h00, 8'h00, 8'h00);
    chk("xrd ptr", acc, 16'h0077);
    ldacc(8'h88);
    ex(OP_XWR_IND, 3'h1, 8'h00, 8'h00, 8'h00);
    chk("xwr ind", u_xfer_mem_model.xram[16'h0041], 16'h0088);
    slow = 1'b1;
    ldacc(8'h00);
    ex(OP_XRD_IND, 3'h1, 8'h00, 8'h00, 8'h00);
    chk("xrd ind", acc, 16'h0088);
    slow = 1'b0;
    $display("test external done");
  endtask
  task automatic t_stack;
    ex(OP_DIR_IMM, 3'h0, 8'h00, 8'h24, 8'h9c);
    ex(OP_PUSH, 3'h0, 8'h24, 8'h00, 8'h00);
    chk("sp push", sp, 16'h0008);
    ex(OP_ACC_DIR, 3'h0, 8'h08, 8'h00, 8'h00);
    chk("stack top", acc, 16'h009c);
    ex(OP_POP, 3'h0, 8'h00, 8'h25, 8'h00);
    chk("sp pop", sp, 16'h0007);
    ex(OP_ACC_DIR, 3'h0, 8'h25, 8'h00, 8'h00);
    chk("pop dst", acc, 16'h009c);
    $display("test stack done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    #100us;
    n_errors++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_direct();
    t_indirect();
    t_swap();
    t_code();
    t_xram();
    t_stack();
    tally_and_finish();
  end
endmodule
